// ===== logic/debug_entry_cause_mask.sv
`timescale 1ns/1ps
`include "debug_entry_regs.svh"

// Functional notes
// RULE_01: load/store breakpoint sets cause bit 28
// RULE_02: instruction breakpoint sets cause bit 29
// RULE_03: any external breakpoint source sets bit 30
// RULE_04: debug station request or reset entry sets 31
// RULE_05: entry needs debug enabled and enable bit
// RULE_06: one enable bit per source, 1 permits
// RULE_07: reset event enable resets to 0
// RULE_08: checkstop enable resets to 1
// RULE_09: machine check enable resets to 0
// RULE_10: external irq, alignment enables reset 0
// RULE_11: program, fp unavailable, decrementer reset 0
// RULE_12: system call enable resets to 0
// RULE_13: trace enable resets to 1
// RULE_14: fp assist, software emulation reset 0
// RULE_15: protection error enables reset to 0
// RULE_16: breakpoint enables 28 and 29 reset 1
// RULE_17: external breakpoint enable gates all, resets 1
// RULE_18: development port irq enable resets 1
// RULE_19: reading cause register clears all bits; kept if debug enabled and not in debug mode
// RULE_20: writes to cause register are ignored
// RULE_21: cause register clears to zero on reset
// RULE_22: every set cause bit qualified by mask
// RULE_23: reserved bits read zero, ignore writes
// RULE_24: request is OR of cause AND mask, qualified

module debug_entry_cause_mask #(
  parameter int SPR_W = 10,
  parameter logic [9:0] CAUSE_NUM = `CAUSE_SPR,
  parameter logic [9:0] ENABLE_NUM = `ENABLE_SPR
) (
  input wire logic core_clk, // core clock, 20 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire debug_entry_pkg::event_type events, // event levels from the core
  input wire logic extBpPin, // external breakpoint pin, asynchronous
  input wire logic debugModeEn, // debug mode globally enabled
  input wire logic inDebugMode, // core is in debug mode
  input wire debug_entry_pkg::spr_req_type sprReq, // register access
  output logic [31:0] sprRdata, // read data, valid with sprAck
  output logic sprAck, // one-cycle answer to a mapped access
  output logic debugEntryReq, // request to enter debug mode
  output logic [31:0] causeFlags, // current cause register
  output logic [31:0] enableMask // current enable register
);

  localparam int W = 32;

  if (SPR_W != 10)
  begin : g_check_width
    $error("register number width must be 10");
  end
  if (CAUSE_NUM == ENABLE_NUM)
  begin : g_check_nums
    $error("the two registers need distinct numbers");
  end

  // documented bit n (0 = msb) sits at vector index W-1-n
  function automatic int unsigned idx(input int unsigned n);
    idx = W - 1 - n;
  endfunction

  // decode of a register number, used for reads and writes
  function automatic debug_entry_pkg::spr_sel_type decode(input logic [9:0] num);
    if (num == CAUSE_NUM)
    begin
      decode = debug_entry_pkg::SPR_CAUSE;
    end
    else if (num == ENABLE_NUM)
    begin
      decode = debug_entry_pkg::SPR_ENABLE;
    end
    else
    begin
      decode = debug_entry_pkg::SPR_NONE;
    end
  endfunction

  // external pin synchroniser
  logic extBpMeta_q;
  logic extBpSync_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      extBpMeta_q <= 1'b0;
      extBpSync_q <= 1'b0;
    end
    else
    begin
      extBpMeta_q <= extBpPin;
      extBpSync_q <= extBpMeta_q;
    end
  end

  // map the event sources onto cause bit positions
  logic [W-1:0] setVec;

  always_comb
  begin
    setVec = '0;
    setVec[idx(`BIT_RESET)] = events.resetEvt;
    setVec[idx(`BIT_CHECKSTOP)] = events.checkstop;
    setVec[idx(`BIT_MACHINE_CHECK)] = events.machineCheck;
    setVec[idx(`BIT_EXT_IRQ)] = events.extIrq;
    setVec[idx(`BIT_ALIGNMENT)] = events.alignment;
    setVec[idx(`BIT_PROGRAM)] = events.programExc;
    setVec[idx(`BIT_FP_UNAVAIL)] = events.fpUnavail;
    setVec[idx(`BIT_DECREMENTER)] = events.decrementer;
    setVec[idx(`BIT_SYSCALL)] = events.syscall;
    setVec[idx(`BIT_TRACE)] = events.trace;
    setVec[idx(`BIT_FP_ASSIST)] = events.fpAssist;
    setVec[idx(`BIT_SW_EMULATION)] = events.swEmulation;
    setVec[idx(`BIT_INSTR_PROTECT)] = events.instrProtect;
    setVec[idx(`BIT_DATA_PROTECT)] = events.dataProtect;
    setVec[idx(`BIT_LOADSTORE_BP)] = events.loadstoreBp; // RULE_01
    setVec[idx(`BIT_INSTR_BP)] = events.instrBp; // RULE_02
    setVec[idx(`BIT_EXTERNAL_BP)] = events.extBpModule | events.extBpDevport | extBpSync_q; // RULE_03
    setVec[idx(`BIT_DEVPORT_IRQ)] = events.devportNmi | events.resetDebugEntry; // RULE_04
  end

  // access decode
  debug_entry_pkg::spr_sel_type sel;
  logic causeRead;
  logic enableWrite;

  always_comb
  begin
    sel = decode(sprReq.num);
    causeRead = sprReq.rd && (sel == debug_entry_pkg::SPR_CAUSE);
    enableWrite = sprReq.wr && (sel == debug_entry_pkg::SPR_ENABLE);
  end

  // a read clears the flags outside debug enable or inside debug mode;
  // while enabled but not yet in debug mode the flags survive the read
  // so the pending entry is not lost
  logic readClear;

  always_comb
  begin
    readClear = causeRead && (!debugModeEn || inDebugMode); // RULE_19
  end

  localparam logic [W-1:0] IMPL = `IMPL_MASK;
  localparam logic [W-1:0] CAUSE_RST = `CAUSE_RESET;
  localparam logic [W-1:0] ENABLE_RST = `ENABLE_RESET;

  // guard the enable reset word against a header edit that flips one default
  if (ENABLE_RST[W - 1 - `BIT_RESET] != 1'b0) // RULE_07
  begin : g_rst_reset
    $error("reset event enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_CHECKSTOP] != 1'b1) // RULE_08
  begin : g_rst_checkstop
    $error("checkstop enable must reset to 1");
  end
  if (ENABLE_RST[W - 1 - `BIT_MACHINE_CHECK] != 1'b0) // RULE_09
  begin : g_rst_machine_check
    $error("machine check enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_EXT_IRQ] != 1'b0) // RULE_10
  begin : g_rst_ext_irq
    $error("external irq enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_ALIGNMENT] != 1'b0) // RULE_10
  begin : g_rst_alignment
    $error("alignment enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_PROGRAM] != 1'b0) // RULE_11
  begin : g_rst_program
    $error("program exception enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_FP_UNAVAIL] != 1'b0) // RULE_11
  begin : g_rst_fp_unavail
    $error("fp unavailable enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_DECREMENTER] != 1'b0) // RULE_11
  begin : g_rst_decrementer
    $error("decrementer enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_SYSCALL] != 1'b0) // RULE_12
  begin : g_rst_syscall
    $error("system call enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_TRACE] != 1'b1) // RULE_13
  begin : g_rst_trace
    $error("trace enable must reset to 1");
  end
  if (ENABLE_RST[W - 1 - `BIT_FP_ASSIST] != 1'b0) // RULE_14
  begin : g_rst_fp_assist
    $error("fp assist enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_SW_EMULATION] != 1'b0) // RULE_14
  begin : g_rst_sw_emulation
    $error("software emulation enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_INSTR_PROTECT] != 1'b0) // RULE_15
  begin : g_rst_instr_protect
    $error("instruction protection enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_DATA_PROTECT] != 1'b0) // RULE_15
  begin : g_rst_data_protect
    $error("data protection enable must reset to 0");
  end
  if (ENABLE_RST[W - 1 - `BIT_LOADSTORE_BP] != 1'b1) // RULE_16
  begin : g_rst_loadstore_bp
    $error("load/store breakpoint enable must reset to 1");
  end
  if (ENABLE_RST[W - 1 - `BIT_INSTR_BP] != 1'b1) // RULE_16
  begin : g_rst_instr_bp
    $error("instruction breakpoint enable must reset to 1");
  end
  if (ENABLE_RST[W - 1 - `BIT_EXTERNAL_BP] != 1'b1) // RULE_17
  begin : g_rst_external_bp
    $error("external breakpoint enable must reset to 1");
  end
  if (ENABLE_RST[W - 1 - `BIT_DEVPORT_IRQ] != 1'b1) // RULE_18
  begin : g_rst_devport_irq
    $error("development port irq enable must reset to 1");
  end

  logic [W-1:0] cause_q;
  logic [W-1:0] enable_q;

  // one sticky flag per bit; reserved positions stay zero
  for (genvar b = 0; b < W; b++)
  begin : g_cause
    if (IMPL[b])
    begin : g_flag
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
        begin
          cause_q[b] <= CAUSE_RST[b]; // RULE_21
        end
        else if (setVec[b])
        begin
          // a set in the clearing cycle wins over the read clear
          cause_q[b] <= 1'b1;
        end
        else if (readClear)
        begin
          cause_q[b] <= 1'b0; // RULE_19
        end
      end
    end
    else
    begin : g_reserved
      always_ff @(posedge core_clk)
      begin
        cause_q[b] <= 1'b0; // RULE_23
      end
    end
  end

  // no write path reaches cause_q: writes to it are acknowledged only
  // RULE_20

  // enable register, one mask bit per source
  for (genvar b = 0; b < W; b++)
  begin : g_enable
    if (IMPL[b])
    begin : g_bit
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
        begin
          enable_q[b] <= ENABLE_RST[b]; // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
        end
        else if (enableWrite)
        begin
          enable_q[b] <= sprReq.wdata[b]; // RULE_06
        end
      end
    end
    else
    begin : g_reserved
      always_ff @(posedge core_clk)
      begin
        enable_q[b] <= 1'b0; // RULE_23
      end
    end
  end

  // register read port, answered one cycle after the access
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sprAck <= 1'b0;
      sprRdata <= '0;
    end
    else
    begin
      sprAck <= (sprReq.rd || sprReq.wr) && (sel != debug_entry_pkg::SPR_NONE);
      case (sel)
        debug_entry_pkg::SPR_CAUSE:
        begin
          sprRdata <= sprReq.rd ? cause_q : '0;
        end
        debug_entry_pkg::SPR_ENABLE:
        begin
          sprRdata <= sprReq.rd ? enable_q : '0;
        end
        default:
        begin
          sprRdata <= '0;
        end
      endcase
    end
  end

  // entry request; a flag whose enable bit is clear stays recorded
  // but never requests entry
  logic anyQualified;

  always_comb
  begin
    anyQualified = |(cause_q & enable_q); // RULE_24 RULE_22 RULE_17
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      debugEntryReq <= 1'b0;
    end
    else
    begin
      debugEntryReq <= debugModeEn && anyQualified; // RULE_05 RULE_22
    end
  end

  // register mirrors for the core
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      causeFlags <= '0;
      enableMask <= ENABLE_RST;
    end
    else
    begin
      causeFlags <= cause_q;
      enableMask <= enable_q;
    end
  end

endmodule

// ===== logic/debug_entry_pkg.sv
package debug_entry_pkg;

  // one level per event source, high while the source asserts
  typedef struct packed {
    logic resetEvt;
    logic checkstop;
    logic machineCheck;
    logic extIrq;
    logic alignment;
    logic programExc;
    logic fpUnavail;
    logic decrementer;
    logic syscall;
    logic trace;
    logic fpAssist;
    logic swEmulation;
    logic instrProtect;
    logic dataProtect;
    logic loadstoreBp;
    logic instrBp;
    logic extBpModule;
    logic extBpDevport;
    logic devportNmi;
    logic resetDebugEntry;
  } event_type;

  // special register access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] num;
    logic [31:0] wdata;
  } spr_req_type;

  typedef enum logic [1:0] {
    SPR_NONE = 2'b00,
    SPR_CAUSE = 2'b01,
    SPR_ENABLE = 2'b10
  } spr_sel_type;

endpackage

// ===== logic/debug_entry_regs.svh
`ifndef DEBUG_ENTRY_REGS_SVH
`define DEBUG_ENTRY_REGS_SVH

// special register numbers of the two registers
`define CAUSE_SPR 10'h094
`define ENABLE_SPR 10'h095

// bit positions, numbered from the most significant bit (bit 0)
`define BIT_RESET 1
`define BIT_CHECKSTOP 2
`define BIT_MACHINE_CHECK 3
`define BIT_EXT_IRQ 6
`define BIT_ALIGNMENT 7
`define BIT_PROGRAM 8
`define BIT_FP_UNAVAIL 9
`define BIT_DECREMENTER 10
`define BIT_SYSCALL 13
`define BIT_TRACE 14
`define BIT_FP_ASSIST 15
`define BIT_SW_EMULATION 17
`define BIT_INSTR_PROTECT 19
`define BIT_DATA_PROTECT 21
`define BIT_LOADSTORE_BP 28
`define BIT_INSTR_BP 29
`define BIT_EXTERNAL_BP 30
`define BIT_DEVPORT_IRQ 31

// implemented bits, shared by both registers; bit 0 is the msb
`define IMPL_MASK 32'h73e7_540f
// reset values
`define CAUSE_RESET 32'h0000_0000
`define ENABLE_RESET 32'h2002_000f

`endif

// ===== verif/core_src_model.sv
`timescale 1ns/1ps
module core_src_model (
  input wire logic core_clk, // core clock
  output debug_entry_pkg::event_type events, // source levels
  output logic extBpPin // breakpoint pin
);
  initial
  begin
    events = '0;
    extBpPin = 1'b0;
  end
  // one-cycle level on source k; 20 is the asynchronous pin
  task automatic pulse(input int k);
    if (k == 20)
      extBpPin = 1'b1;
    else
      events[k] = 1'b1;
    @(posedge core_clk) #1;
    events = '0;
    extBpPin = 1'b0;
  endtask
endmodule

// ===== verif/debug_entry_cause_mask_chk.sv
`timescale 1ns/1ps
`include "debug_entry_regs.svh"
module debug_entry_cause_mask_chk (
  input wire logic core_clk, // clock
  input wire logic rstn, // reset
  input wire debug_entry_pkg::event_type events, // sources
  input wire logic extBpPin, // pin
  input wire logic debugModeEn, // global enable
  input wire logic inDebugMode, // in debug
  input wire debug_entry_pkg::spr_req_type sprReq, // access
  input wire logic [31:0] sprRdata, // read data
  input wire logic sprAck, // answer
  input wire logic debugEntryReq, // entry request
  input wire logic [31:0] causeFlags, // cause copy
  input wire logic [31:0] enableMask // mask copy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic anyAcc = sprReq.rd | sprReq.wr;
  wire logic rdCause = sprReq.rd && sprReq.num == `CAUSE_SPR;
  wire logic mapped = sprReq.num == `CAUSE_SPR || sprReq.num == `ENABLE_SPR;
  a_lsbp_flag: assert property (events.loadstoreBp |-> ##2 causeFlags[3]) else $error("bit 28 not set");
  a_ibp_flag: assert property (events.instrBp |-> ##2 causeFlags[2]) else $error("bit 29 not set");
  a_ext_flag: assert property (events.extBpModule || events.extBpDevport |-> ##2 causeFlags[1])
    else $error("bit 30 not set");
  a_dpi_flag: assert property (events.devportNmi || events.resetDebugEntry |-> ##2 causeFlags[0])
    else $error("bit 31 not set");
  a_entry_gate: assert property (debugEntryReq == (|(causeFlags & enableMask) && $past(debugModeEn)))
    else $error("entry request wrong");
  a_mask_write: assert property (sprReq.wr && sprReq.num == `ENABLE_SPR |->
    ##2 enableMask == ($past(sprReq.wdata, 2) & `IMPL_MASK)) else $error("mask write wrong");
  a_read_data: assert property (rdCause |=> sprRdata == causeFlags) else $error("cause read wrong");
  a_read_clear: assert property (rdCause && (!debugModeEn || inDebugMode) && events == '0
    && !$past(extBpPin, 2) |-> ##2 causeFlags == '0) else $error("cause not cleared");
  a_ack_unmapped: assert property (anyAcc && !mapped |=> !sprAck) else $error("unmapped acked");
  a_rdata_idle: assert property (!sprAck |-> sprRdata == '0) else $error("read data not idle");
  c_entry: cover property (debugEntryReq);
  c_clear: cover property (rdCause && !debugModeEn);
  c_unmapped: cover property (anyAcc && !mapped);
endmodule

// ===== verif/test_debug_entry_cause_mask.sv
`timescale 1ns/1ps
`include "debug_entry_regs.svh"
module test_debug_entry_cause_mask;
  logic core_clk;
  logic rstn;
  logic debugModeEn;
  logic inDebugMode;
  debug_entry_pkg::event_type events;
  logic extBpPin;
  debug_entry_pkg::spr_req_type sprReq;
  logic [31:0] sprRdata;
  logic sprAck;
  logic debugEntryReq;
  logic [31:0] causeFlags;
  logic [31:0] enableMask;
  int n_fail;
  int checked;
  // documented cause bit of each source, 20 is the pin
  int docBit[21] = '{31, 31, 30, 30, 29, 28, 21, 19, 17, 15, 14, 13, 10, 9, 8, 7, 6, 3, 2, 1, 30};
  logic [31:0] mc;
  logic [31:0] me;
  logic [31:0] q;
  logic [31:0] wd;
  logic ack;

  debug_entry_cause_mask dut_u (.core_clk(core_clk), .rstn(rstn), .events(events), .extBpPin(extBpPin),
    .debugModeEn(debugModeEn), .inDebugMode(inDebugMode), .sprReq(sprReq), .sprRdata(sprRdata),
    .sprAck(sprAck), .debugEntryReq(debugEntryReq), .causeFlags(causeFlags), .enableMask(enableMask));
  core_src_model src_u (.core_clk(core_clk), .events(events), .extBpPin(extBpPin));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a spare cycle first keeps two requests from sharing one time step
  task automatic acc(input logic r, input logic w, input logic [9:0] n, input logic [31:0] d);
    @(posedge core_clk) #1;
    sprReq = {r, w, n, d};
    @(posedge core_clk) #1;
    sprReq = '0;
    q = sprRdata;
    ack = sprAck;
  endtask

  task automatic reset_dut();
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    mc = '0;
    me = 32'h2002_000f;
    chk(causeFlags, mc);
    chk(enableMask, me);
  endtask

  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    n_fail = 0;
    checked = 0;
    debugModeEn = 1'b0;
    inDebugMode = 1'b0;
    sprReq = '0;
    q = $urandom(32'h7ab01e7d);
    reset_dut();
    acc(1'b1, 1'b1, 10'h0ff, 32'h0);
    chk({31'h0, ack}, 32'h0);
    for (int k = 0; k < 21; k++)
    begin
      wd = $urandom;
      acc(1'b0, 1'b1, `ENABLE_SPR, wd);
      me = wd & `IMPL_MASK;
      acc(1'b1, 1'b0, `ENABLE_SPR, 32'h0);
      chk(q, me);
      {debugModeEn, inDebugMode} = 2'($urandom);
      src_u.pulse(k);
      mc[31 - docBit[k]] = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(causeFlags, mc);
      chk({31'h0, debugEntryReq}, {31'h0, debugModeEn && |(mc & me)});
      acc(1'b0, 1'b1, `CAUSE_SPR, 32'hffff_ffff);
      chk({31'h0, ack}, 32'h1);
      acc(1'b1, 1'b0, `CAUSE_SPR, 32'h0);
      chk({31'h0, ack}, 32'h1);
      chk(q, mc);
      if (!debugModeEn || inDebugMode)
        mc = '0;
    end
    reset_dut();
    conclude();
  end

  // the loop needs about 250 cycles, well under the 4000-cycle limit
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule

bind debug_entry_cause_mask debug_entry_cause_mask_chk chk_u (.core_clk(core_clk), .rstn(rstn), .events(events),
  .extBpPin(extBpPin), .debugModeEn(debugModeEn), .inDebugMode(inDebugMode), .sprReq(sprReq), .sprRdata(sprRdata),
  .sprAck(sprAck), .debugEntryReq(debugEntryReq), .causeFlags(causeFlags), .enableMask(enableMask));
